// ==== verilog/olmi_pkg.sv ====
// constants and types shared by the optical link mode indicator block
// assumes a 200 MHz system clock and a 32-bit classic Wishbone register bus
package olmi_pkg;

   // ****************************************
   // operating modes, one-hot
   // ****************************************
   typedef enum logic [4:0]
   {
      NORMAL_TRANSFER_MODE = 5'h01,
      HAND_TUNE_MODE = 5'h02,
      ALIGNMENT_TUNE_MODE = 5'h04,
      POINTER_BEAM_MODE = 5'h08,
      DROPOUT_LATCH_MODE = 5'h10
   } olmi_mode_t;

   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_LEVEL = 4'h8;

   // ctrl fields
   localparam int CTRL_CARRIER_B_BIT = 0;
   localparam int CTRL_STEP_BIT = 1;
   localparam logic CARRIER_B_RST = 1'b1;

   // status fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_LINK_BIT = 5;
   localparam int STAT_WARN_BIT = 6;
   localparam int STAT_TRIP_BIT = 7;
   localparam int STAT_CARRIER_BIT = 8;

   // level fields
   localparam int LVL_LOCAL_LSB = 0;
   localparam int LVL_PEER_LSB = 8;
   localparam int LVL_BAR_LSB = 16;

   // ****************************************
   // level and bargraph geometry
   // ****************************************
   localparam int LVL_W = 8;
   localparam int SEG_N = 10;
   localparam int RED_N = 2;
   localparam int ORANGE_N = 3;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_FREQ_MHZ = 200;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYC = TICK_TIME_US * CLK_FREQ_MHZ;
   localparam int DEB_TICKS = 4;

endpackage

// ==== verilog/olmi_sel_debounce.sv ====
// debounces the mode selector push and gives one pulse per press
// assumes the raw input is synchronous to the clock and tick_in is a one-cycle enable
`timescale 1ns/100ps
module olmi_sel_debounce
   import olmi_pkg::*;
#(
   parameter int DEB_N = DEB_TICKS
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // sampling
   input wire logic tick_in,
   input wire logic raw_in,
   // result
   output logic press_out
);

   logic stable_ff;
   logic [7:0] cnt_ff;
   logic press_ff;
   logic differs;
   logic settled;

   assign differs = raw_in != stable_ff;
   assign settled = tick_in && differs && (cnt_ff == 8'(DEB_N - 1));

   // a level must stay changed for DEB_N ticks before it counts
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         stable_ff <= 1'b0;
         cnt_ff <= 8'h00;
         press_ff <= 1'b0;
      end
      else
      begin
         if (tick_in)
            cnt_ff <= (differs && !settled) ? cnt_ff + 8'h01 : 8'h00;
         if (settled)
            stable_ff <= raw_in;
         press_ff <= settled && raw_in;
      end
   end

   assign press_out = press_ff;

endmodule // olmi_sel_debounce

// ==== verilog/olmi_bargraph.sv ====
// turns a received level code into a thermometer bargraph
// assumes segment 0 is the lowest red segment
`timescale 1ns/100ps
module olmi_bargraph
   import olmi_pkg::*;
#(
   parameter int L_W = LVL_W,
   parameter int S_N = SEG_N
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // level
   input wire logic [L_W-1:0] level_in,
   // segments
   output logic [S_N-1:0] seg_out
);

   localparam int STEP = (2 ** L_W) / (S_N + 1);

   logic [S_N-1:0] nxt_seg;
   logic [S_N-1:0] seg_ff;

   genvar i;
   generate
      for (i = 0; i < S_N; i = i + 1)
      begin : g_seg
         localparam logic [L_W:0] THR = (L_W + 1)'(STEP * (i + 1));
         assign nxt_seg[i] = {1'b0, level_in} >= THR;
      end
   endgenerate

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         seg_ff <= '0;
      else
         seg_ff <= nxt_seg;
   end

   assign seg_out = seg_ff;

endmodule // olmi_bargraph

// ==== verilog/olmi_top.sv ====
// mode selection, link hold and indicator logic for one optical link station
// assumes the receive level and peer level are sampled codes synchronous to REF_CLK_IN
// assumes the Wishbone master is a classic single-cycle master
//
// Function
// RULE_01: local received level measured continuously and shown on the bargraph.
// RULE_02: warning asserted when the bargraph shows only red and orange.
// RULE_03: warning drives the switching output of the power connector.
// RULE_04: carrier indicator dark for carrier A, lit for carrier B, default B.
// RULE_05: selector steps modes; mode lamps show the active mode.
// RULE_06: normal mode passes data, link held until last orange goes dark.
// RULE_07: hand-tune mode holds link only until last green goes dark.
// RULE_08: alignment-tune mode stops data, link held until last orange dark.
// RULE_09: alignment-tune mode shows the peer level on the local bargraph.
// RULE_10: pointer-beam mode switches alignment laser on, lamp green.
// RULE_11: latch lamp dark when inactive, green while no interruption seen.
// RULE_12: after any interruption in latch mode the lamp stays red.
// RULE_13: the two stations of one path use different carriers.
// RULE_14: each selector press advances mode cyclically; one lamp lit.
// RULE_15: entering latch mode clears any earlier latched interruption.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module olmi_top
   import olmi_pkg::*;
#(
   parameter int TICK_N = TICK_CYC,
   parameter int L_W = LVL_W,
   parameter int S_N = SEG_N,
   parameter int R_N = RED_N,
   parameter int O_N = ORANGE_N
)
(
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,

   // wishbone slave
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [3:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,

   // operator and optics
   input wire logic SELECTOR_IN,
   input wire logic [L_W-1:0] RX_LEVEL_IN,

   // level exchange with the peer
   input wire logic [L_W-1:0] PEER_LEVEL_IN,
   output logic [L_W-1:0] LOCAL_LEVEL_OUT,

   // indicators
   output logic [S_N-1:0] BARGRAPH_OUT,
   output logic [3:0] MODE_LAMP_OUT,
   output logic LATCH_LAMP_GREEN_OUT,
   output logic LATCH_LAMP_RED_OUT,
   output logic CARRIER_SELECT_INDICATOR_OUT,

   // link and system outputs
   output logic LINK_UP_OUT,
   output logic DATA_PASS_OUT,
   output logic POINTER_LASER_OUT,
   output logic WARNING_SWITCH_OUTPUT_OUT,
   output logic CARRIER_B_OUT
);

   // ****************************************
   // declarations
   // ****************************************
   localparam int TICK_W = $clog2(TICK_N + 1);

   logic [TICK_W-1:0] tick_cnt_ff;
   logic tick;
   logic press;

   olmi_mode_t mode_ff;
   olmi_mode_t nxt_mode;
   logic step_req;
   logic sw_step;

   logic [S_N-1:0] loc_seg;
   logic [S_N-1:0] peer_seg;
   logic orange_lit;
   logic green_lit;
   logic keep_link;

   logic link_up_ff;
   logic warn_ff;
   logic trip_ff;
   logic carrier_b_ff;
   logic [L_W-1:0] local_level_ff;
   logic [S_N-1:0] bar_ff;

   logic in_align;
   logic in_hand;
   logic in_latch;
   logic enter_latch;
   logic link_lost;
   logic set_trip;
   logic [S_N-1:0] nxt_bar;

   logic wb_req;
   logic ack_ff;
   logic [31:0] rd_ff;
   logic wr_now;
   logic hit_ctrl;
   logic hit_status;
   logic hit_level;
   logic [31:0] rd_mux;
   logic [31:0] status_word;
   logic [31:0] level_word;
   logic take_req;
   logic wr_ctrl;

   // ****************************************
   // slow tick for the selector debounce
   // ****************************************
   // limitation: a push shorter than DEB_N ticks never steps the mode
   assign tick = tick_cnt_ff == TICK_W'(TICK_N - 1);

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         tick_cnt_ff <= '0;
      else if (tick)
         tick_cnt_ff <= '0;
      else
         tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
   end

   olmi_sel_debounce u_sel
   (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RST_N_IN),
      .tick_in(tick),
      .raw_in(SELECTOR_IN),
      .press_out(press)
   );

   // ****************************************
   // level measurement and bargraph
   // ****************************************
   // every cycle, no gating: the measurement never pauses
   olmi_bargraph #(.L_W(L_W), .S_N(S_N)) u_loc_bar // see RULE_01
   (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RST_N_IN),
      .level_in(RX_LEVEL_IN),
      .seg_out(loc_seg)
   );

   olmi_bargraph #(.L_W(L_W), .S_N(S_N)) u_peer_bar
   (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RST_N_IN),
      .level_in(PEER_LEVEL_IN),
      .seg_out(peer_seg)
   );

   // thermometer code: the lowest segment of a colour tells if any of it is lit
   assign orange_lit = loc_seg[R_N];
   assign green_lit = loc_seg[R_N + O_N];

   // ****************************************
   // mode selection
   // ****************************************
   assign step_req = press || sw_step; // see RULE_05
   assign in_align = mode_ff == ALIGNMENT_TUNE_MODE;
   assign in_hand = mode_ff == HAND_TUNE_MODE;
   assign in_latch = mode_ff == DROPOUT_LATCH_MODE;
   assign enter_latch = step_req && (mode_ff == POINTER_BEAM_MODE);

   always_comb
   begin
      nxt_mode = mode_ff;
      if (step_req)
      begin
         unique case (mode_ff) // see RULE_14
            NORMAL_TRANSFER_MODE: nxt_mode = HAND_TUNE_MODE;
            HAND_TUNE_MODE: nxt_mode = ALIGNMENT_TUNE_MODE;
            ALIGNMENT_TUNE_MODE: nxt_mode = POINTER_BEAM_MODE;
            POINTER_BEAM_MODE: nxt_mode = DROPOUT_LATCH_MODE;
            DROPOUT_LATCH_MODE: nxt_mode = NORMAL_TRANSFER_MODE;
            default: nxt_mode = NORMAL_TRANSFER_MODE;
         endcase
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         mode_ff <= NORMAL_TRANSFER_MODE;
      else
         mode_ff <= nxt_mode;
   end

   // ****************************************
   // link hold and warning
   // ****************************************
   // hand-tune drops on the last green segment, every other mode on the last orange
   assign keep_link = in_hand ? green_lit : orange_lit; // see RULE_06 see RULE_07 see RULE_08
   assign link_lost = link_up_ff && !keep_link;

   // no hysteresis: a level hovering on a threshold will chatter the link
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         link_up_ff <= 1'b0;
      else
         link_up_ff <= keep_link;
   end

   // warning follows the local level, even while the peer level is on display
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         warn_ff <= 1'b0;
      else
         warn_ff <= !green_lit; // see RULE_02
   end

   // copy sent to the peer, shown there in alignment-tune mode
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         local_level_ff <= '0;
      else
         local_level_ff <= RX_LEVEL_IN;
   end

   // ****************************************
   // dropout latch
   // ****************************************
   // the clear only happens on entry, before the mode is live, so a loss cannot be masked
   // a loss wins over any clear in the same cycle
   assign set_trip = in_latch && link_lost; // see RULE_12

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         trip_ff <= 1'b0;
      else if (set_trip)
         trip_ff <= 1'b1; // see RULE_12
      else if (enter_latch)
         trip_ff <= 1'b0; // see RULE_15
   end

   // ****************************************
   // displayed bargraph
   // ****************************************
   // peer and local pass the same pair of registers, so a mode switch shows no stale mix
   assign nxt_bar = in_align ? peer_seg : loc_seg; // see RULE_09

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         bar_ff <= '0;
      else
         bar_ff <= nxt_bar;
   end

   // ****************************************
   // wishbone slave
   // ****************************************
   // one wait state: ack rises the cycle after the request, data already registered
   assign wb_req = WB_CYC_IN && WB_STB_IN;
   assign take_req = wb_req && !ack_ff;
   // writes land on the ack edge, when the master is known to still hold the data
   assign wr_now = wb_req && ack_ff && WB_WE_IN;
   assign hit_ctrl = WB_ADR_IN == ADDR_CTRL;
   assign hit_status = WB_ADR_IN == ADDR_STATUS;
   assign hit_level = WB_ADR_IN == ADDR_LEVEL;
   assign wr_ctrl = wr_now && hit_ctrl && WB_SEL_IN[0];
   // step is a pulse, never stored, so the control word reads it back as zero
   assign sw_step = wr_ctrl && WB_DAT_IN[CTRL_STEP_BIT];

   assign status_word = {23'h000000,
                         carrier_b_ff,
                         trip_ff,
                         warn_ff,
                         link_up_ff,
                         mode_ff};
   assign level_word = {{(32 - S_N - 16){1'b0}},
                        bar_ff,
                        8'(PEER_LEVEL_IN),
                        8'(local_level_ff)};

   // unmapped addresses read as zero and are still acknowledged
   assign rd_mux = hit_ctrl ? {31'h00000000, carrier_b_ff} :
                   hit_status ? status_word :
                   hit_level ? level_word :
                   32'h00000000;

   // ack drops after one cycle, so a held request is taken again only every second cycle
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         ack_ff <= 1'b0;
      else
         ack_ff <= take_req;
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         rd_ff <= 32'h00000000;
      else if (take_req)
         rd_ff <= rd_mux;
   end

   // ****************************************
   // carrier selection
   // ****************************************
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         carrier_b_ff <= CARRIER_B_RST; // see RULE_04
      else if (wr_ctrl)
         carrier_b_ff <= WB_DAT_IN[CTRL_CARRIER_B_BIT];
   end

   // ****************************************
   // outputs
   // ****************************************
   assign WB_ACK_OUT = ack_ff;
   assign WB_DAT_OUT = rd_ff;
   assign LOCAL_LEVEL_OUT = local_level_ff;
   assign BARGRAPH_OUT = bar_ff; // see RULE_01

   // mode lamps, latch lamp split into its two colours
   assign MODE_LAMP_OUT = mode_ff[3:0]; // see RULE_05
   assign LATCH_LAMP_GREEN_OUT = in_latch && !trip_ff; // see RULE_11
   assign LATCH_LAMP_RED_OUT = in_latch && trip_ff; // see RULE_12

   assign CARRIER_SELECT_INDICATOR_OUT = carrier_b_ff; // see RULE_04
   assign CARRIER_B_OUT = carrier_b_ff;

   assign LINK_UP_OUT = link_up_ff;
   assign DATA_PASS_OUT = link_up_ff && !in_align; // see RULE_08
   assign POINTER_LASER_OUT = mode_ff == POINTER_BEAM_MODE; // see RULE_10
   assign WARNING_SWITCH_OUTPUT_OUT = warn_ff; // see RULE_03

endmodule // olmi_top

// ==== verification/olmi_peer_station.sv ====
// model of the opposing station: measures what it receives and sends it back
// assumes one clock shared with the device
`timescale 1ns/100ps
module olmi_peer_station
   import olmi_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // optics
   input wire logic [LVL_W-1:0] own_rx_level_in,
   input wire logic near_carrier_b_in,
   // link towards the device
   output logic [LVL_W-1:0] level_out,
   output logic carrier_b_out
);
   // ****************************************
   // level report
   // ****************************************
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         level_out <= '0;
      end
      else
      begin
         level_out <= own_rx_level_in;
      end
   end
   // installer always picks the other carrier
   assign carrier_b_out = !near_carrier_b_in;
endmodule // olmi_peer_station

// ==== verification/olmi_monitor.sv ====
// checker for the mode and link indicator outputs
// assumes it is bound into olmi_top and sees only its ports
`timescale 1ns/100ps
module olmi_monitor
   import olmi_pkg::*;
#(
   parameter int S_N = SEG_N
)
(
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   // bus
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_ACK_OUT,
   // indicators and link
   input wire logic [S_N-1:0] BARGRAPH_OUT,
   input wire logic [3:0] MODE_LAMP_OUT,
   input wire logic LATCH_LAMP_GREEN_OUT,
   input wire logic LATCH_LAMP_RED_OUT,
   input wire logic LINK_UP_OUT,
   input wire logic DATA_PASS_OUT,
   input wire logic POINTER_LASER_OUT,
   input wire logic WARNING_SWITCH_OUTPUT_OUT
);
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   AST_ACK: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
      else $error("ack not one pulse after request");
   AST_ONE_LAMP: assert property ($onehot({MODE_LAMP_OUT, LATCH_LAMP_GREEN_OUT | LATCH_LAMP_RED_OUT}))
      else $error("not exactly one mode lamp");
   AST_LASER: assert property (POINTER_LASER_OUT == MODE_LAMP_OUT[3])
      else $error("laser not tied to pointer mode");
   AST_DATA: assert property (DATA_PASS_OUT == (LINK_UP_OUT && !MODE_LAMP_OUT[2]))
      else $error("data pass wrong");
   AST_WARN: assert property (MODE_LAMP_OUT[0] && $past(MODE_LAMP_OUT[0], 3) && $past(RST_N_IN, 3)
      |-> WARNING_SWITCH_OUTPUT_OUT == !BARGRAPH_OUT[5]) else $error("warning not at green edge");
   AST_LINK_HAND: assert property (MODE_LAMP_OUT[1] && $past(MODE_LAMP_OUT[1], 3)
      |-> LINK_UP_OUT == BARGRAPH_OUT[5]) else $error("hand link threshold");
   AST_LINK_NORM: assert property (MODE_LAMP_OUT[0] && $past(MODE_LAMP_OUT[0], 3) && $past(RST_N_IN, 3)
      |-> LINK_UP_OUT == BARGRAPH_OUT[2]) else $error("normal link threshold");
   AST_RED: assert property (LATCH_LAMP_RED_OUT |=> LATCH_LAMP_RED_OUT || MODE_LAMP_OUT[0])
      else $error("red lamp not sticky");
   AST_TRIP: assert property ($past(LATCH_LAMP_GREEN_OUT) && $fell(LINK_UP_OUT) |-> LATCH_LAMP_RED_OUT || MODE_LAMP_OUT[0])
      else $error("dropout not latched");
   AST_STEP: assert property ($rose(MODE_LAMP_OUT[1]) |-> $past(MODE_LAMP_OUT[0]))
      else $error("hand mode not after normal");
   AST_ENTRY: assert property ($rose(LATCH_LAMP_GREEN_OUT) |-> $past(MODE_LAMP_OUT[3]))
      else $error("latch entry not after pointer");
endmodule // olmi_monitor

bind olmi_top olmi_monitor #(.S_N(S_N)) i_mon (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
   .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT), .BARGRAPH_OUT(BARGRAPH_OUT),
   .MODE_LAMP_OUT(MODE_LAMP_OUT), .LATCH_LAMP_GREEN_OUT(LATCH_LAMP_GREEN_OUT),
   .LATCH_LAMP_RED_OUT(LATCH_LAMP_RED_OUT), .LINK_UP_OUT(LINK_UP_OUT), .DATA_PASS_OUT(DATA_PASS_OUT),
   .POINTER_LASER_OUT(POINTER_LASER_OUT), .WARNING_SWITCH_OUTPUT_OUT(WARNING_SWITCH_OUTPUT_OUT));

// ==== verification/tb_optical_link_mode_indicator.sv ====
// self-checking bench for the optical link mode indicator
// assumes the peer model and the bound checker are compiled first
`timescale 1ns/100ps
module tb_optical_link_mode_indicator;
   import olmi_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, btn = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic [7:0] rx = 8'h0, prx = 8'h0, plvl, llvl;
   logic [9:0] bar;
   logic [3:0] lamps;
   logic ack, lg, lr, ind, link, pass, laser, warn, cb, pcb;
   int bad_count = 0;
   int checks_done = 0;
   int md = 0, trip = 0, up = 0, cur = 0;
   int seed;

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   // short tick keeps debounce at 16 cycles
   olmi_top #(.TICK_N(4)) i_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .SELECTOR_IN(btn), .RX_LEVEL_IN(rx), .PEER_LEVEL_IN(plvl), .LOCAL_LEVEL_OUT(llvl), .BARGRAPH_OUT(bar),
      .MODE_LAMP_OUT(lamps), .LATCH_LAMP_GREEN_OUT(lg), .LATCH_LAMP_RED_OUT(lr),
      .CARRIER_SELECT_INDICATOR_OUT(ind), .LINK_UP_OUT(link), .DATA_PASS_OUT(pass),
      .POINTER_LASER_OUT(laser), .WARNING_SWITCH_OUTPUT_OUT(warn), .CARRIER_B_OUT(cb));
   olmi_peer_station i_peer (.clk_in(clk), .rst_n_in(rst_n), .own_rx_level_in(prx),
      .near_carrier_b_in(ind), .level_out(plvl), .carrier_b_out(pcb));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
      end
      while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(negedge clk);
   endtask

   task automatic enter(input int n);
      md = (md + n) % 5;
      if (md == 4)
      begin
         trip = 0;
         up = (cur >= 69);
      end
   endtask

   // sets both levels and compares every indicator except the carrier select indicator with the model
   task automatic lvl(input int l, input int p);
      int sh, th, e;
      @(posedge clk);
      rx <= l[7:0];
      prx <= p[7:0];
      cur = l;
      repeat (6) @(posedge clk);
      @(negedge clk);
      sh = (md == 2) ? p : l;
      th = (md == 1) ? 138 : 69;
      e = (l >= th);
      if (md == 4 && up && !e)
      begin
         trip = 1;
      end
      up = e;
      chk(32'(bar), (32'h1 << ((sh / 23 > 10) ? 10 : sh / 23)) - 1, "bar");
      chk(32'(llvl), l, "local level");
      chk(32'(link), e, "link");
      chk(32'(warn), l < 138, "warning");
      chk(32'(pass), e && md != 2, "pass");
      chk(32'(lamps), (md < 4) ? (1 << md) : 0, "lamps");
      chk(32'(laser), md == 3, "laser");
      chk(32'({lg, lr}), (md == 4) ? (trip ? 1 : 2) : 0, "latch lamp");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      $display("MISMATCH %0t watchdog expired", $time);
      bad_count++;
      final_report();
   end

   initial
   begin
      seed = $urandom(6);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h141, "status after reset");
      wb(1'b0, 4'hC, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      wb(1'b1, ADDR_CTRL, 32'h0);
      chk(32'(ind), 0, "carrier a");
      chk(32'(cb), 0, "carrier out a");
      chk(32'(pcb), 1, "peer carrier b");
      // lane 0 disabled: the write must be ignored
      @(posedge clk);
      sel <= 4'hE;
      wb(1'b1, ADDR_CTRL, 32'h1);
      chk(32'(ind), 0, "masked write");
      @(posedge clk);
      sel <= 4'hF;
      wb(1'b1, ADDR_CTRL, 32'h1);
      chk(32'(ind), 1, "carrier b");
      chk(32'(cb), 1, "carrier out b");
      chk(32'(pcb), 0, "peer carrier a");
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h1, "ctrl read");
      $display("test registers done");
      for (int m = 0; m < 4; m++)
      begin
         repeat (6) lvl($urandom_range(255), $urandom_range(255));
         lvl(138, 0);
         lvl(137, 255);
         lvl(69, 255);
         lvl(68, 0);
         wb(1'b1, ADDR_CTRL, 32'h3);
         enter(1);
      end
      $display("test levels done");
      lvl(200, 0);
      lvl(0, 0);
      lvl(200, 0);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h1B0, "status latched");
      wb(1'b1, ADDR_CTRL, 32'h3);
      enter(1);
      lvl(200, 0);
      repeat (4) wb(1'b1, ADDR_CTRL, 32'h3);
      enter(4);
      lvl(200, 0);
      $display("test latch done");
      // only the press edge steps; release must not step again
      repeat (2)
      begin
         @(posedge clk);
         btn <= 1'b1;
         repeat (40) @(posedge clk);
         btn <= 1'b0;
         repeat (40) @(posedge clk);
         enter(1);
         lvl(150, 30);
      end
      wb(1'b0, ADDR_LEVEL, 32'h0);
      chk(rd, 32'h003F1E96, "level read");
      $display("test selector done");
      final_report();
   end
endmodule // tb_optical_link_mode_indicator
